// file: bench/lsqu_l2_model.sv
`timescale 1ns/1ps
module lsqu_l2_model
	import lsqu_pkg::*;
(
	// Clock and reset
	input  wire logic			sys_clk,
	input  wire logic			sys_rst,
	// Translation reload
	input  wire logic			tlb_req,
	input  wire logic [AW-PG_W-1:0]	tlb_vpn,
	output logic				tlb_rsp,
	output logic [AW-PG_W-1:0]		tlb_rpn,
	// Line reload and store sink
	input  wire logic			l2_rd,
	input  wire logic [AW-LN_W-1:0]	l2_rd_line,
	output logic				l2_fill,
	output logic [AW-LN_W-1:0]		l2_fill_line,
	output logic [1:0]			l2_fill_beat,
	output logic [FILL_W-1:0]		l2_fill_data,
	input  wire logic			l2_st_valid,
	output logic				l2_st_ready
);
	logic [3:0]		tcnt, fcnt;
	logic [1:0]		scnt;
	logic [AW-PG_W-1:0]	vpn;
	logic [AW-LN_W-1:0]	line;

	// ==========================================
	// Translation answer, identity mapped
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tcnt <= 4'h0;
			tlb_rsp <= 1'b0;
			tlb_rpn <= '0;
			vpn <= '0;
		end else begin
			tlb_rsp <= (tcnt == 4'h1);
			tlb_rpn <= (tcnt == 4'h1) ? vpn : ~tlb_rpn;
			if (tlb_req) begin
				tcnt <= 4'ha;
				vpn <= tlb_vpn;
			end else if (tcnt != 4'h0)
				tcnt <= tcnt - 4'h1;
		end
	end

	// ==========================================
	// Four beats in order; each dword carries its line and index
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fcnt <= 4'h0;
			line <= '0;
			l2_fill <= 1'b0;
			l2_fill_line <= '0;
			l2_fill_beat <= 2'h0;
			l2_fill_data <= '0;
		end else begin
			l2_fill <= (fcnt != 4'h0) && (fcnt <= 4'h4);
			l2_fill_line <= line;
			l2_fill_beat <= 2'(4'h4 - fcnt);
			for (int k = 0; k < 4; k++)
				l2_fill_data[64*k+:64] <= (fcnt != 4'h0 && fcnt <= 4'h4) ?
					{line[31:0], 28'h0, 2'(4'h4 - fcnt), 2'(k)} : ~l2_fill_data[64*k+:64];
			if (l2_rd) begin
				fcnt <= 4'hc;
				line <= l2_rd_line;
			end else if (fcnt != 4'h0)
				fcnt <= fcnt - 4'h1;
		end
	end

	// ==========================================
	// Store sink stalls three cycles in four
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scnt <= 2'h0;
			l2_st_ready <= 1'b0;
		end else if (l2_st_valid) begin
			scnt <= scnt + 2'h1;
			l2_st_ready <= (scnt == 2'h2);
		end
	end
endmodule

// file: bench/tb_load_store_queue_unit.sv
`timescale 1ns/1ps
`define CHK(a, e) \
	begin \
		n_tests++; \
		if ((a) !== (e)) begin \
			errors++; \
			$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
		end \
	end
module tb_load_store_queue_unit
	import lsqu_pkg::*;
;
	logic			sys_clk, sys_rst, ce, hit, fwb0, fwb1;
	logic			disp_valid, disp_st, disp_ready, iss_valid, iss_ready;
	logic			rej_valid, wb_valid, ld_retire, st_cmpl, flush, ord_hazard;
	logic			tlb_req, tlb_rsp, l1_wr, l1_fill, l1_inval, l2_rd, l2_fill;
	logic			l2_castout, l2_st_valid, l2_st_ready;
	logic [1:0]		fwb_valid, l1_fill_beat, l2_fill_beat, l1_tv;
	logic [4:0]		rf_idx, st_cmpl_idx;
	logic [QI:0]		flush_lq_tail, flush_sq_tail;
	logic [63:0]		rf_data, l1_dw [2];
	logic [AW-1:0]		l1_rd_ea;
	logic [AW-PG_W-1:0]	tlb_vpn, tlb_rpn;
	logic [AW-LN_W-1:0]	l1_tag [2], l1_fill_line, l1_inval_line, l2_rd_line;
	logic [AW-LN_W-1:0]	l2_fill_line, l2_castout_line;
	logic [FILL_W-1:0]	l1_fill_data, l2_fill_data;
	lsqu_tag_t		disp_tag, rej_tag, ord_tag;
	lsqu_iss_t		iss_op;
	lsqu_wb_t		wb, fwb [2];
	lsqu_st_t		l1_wr_op, l2_st;
	int			errors, n_tests, cyc, n_rd, n_wr;

	lsqu_unit dut (.sys_clk, .sys_rst, .ce, .disp_valid, .disp_st, .disp_ready, .disp_tag,
		.iss_valid, .iss_op, .iss_ready, .rej_valid, .rej_tag, .rf_idx, .rf_data, .wb,
		.wb_valid, .fwb, .fwb_valid, .ld_retire, .st_cmpl, .st_cmpl_idx, .flush,
		.flush_lq_tail, .flush_sq_tail, .ord_hazard, .ord_tag, .tlb_req, .tlb_vpn,
		.tlb_rsp, .tlb_rpn, .l1_rd_ea, .l1_tv, .l1_tag, .l1_dw, .l1_wr, .l1_wr_op,
		.l1_fill, .l1_fill_line, .l1_fill_beat, .l1_fill_data, .l1_inval, .l1_inval_line,
		.l2_rd, .l2_rd_line, .l2_fill, .l2_fill_line, .l2_fill_beat, .l2_fill_data,
		.l2_castout, .l2_castout_line, .l2_st_valid, .l2_st_ready, .l2_st);
	lsqu_l2_model l2m (.sys_clk, .sys_rst, .tlb_req, .tlb_vpn, .tlb_rsp, .tlb_rpn, .l2_rd,
		.l2_rd_line, .l2_fill, .l2_fill_line, .l2_fill_beat, .l2_fill_data, .l2_st_valid,
		.l2_st_ready);

	// ==========================================
	// L1 array: way 0 holds the addressed line when hit is set
	assign l1_tv = {1'b0, hit};
	assign l1_tag[0] = l1_rd_ea[AW-1:LN_W];
	assign l1_tag[1] = ~l1_rd_ea[AW-1:LN_W];
	assign l1_dw[0] = {24'h0, l1_rd_ea};
	assign l1_dw[1] = ~{24'h0, l1_rd_ea};
	assign fwb0 = fwb_valid[0];
	assign fwb1 = fwb_valid[1];

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		n_rd += (l2_rd === 1'b1);
		n_wr += (l1_wr === 1'b1);
		cyc++;
		if (cyc == 2000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 30 && s !== 1'b1; i++)
			@(negedge sys_clk);
	endtask

	task automatic dispatch(input logic st, output lsqu_tag_t t);
		disp_valid = 1'b1;
		disp_st = st;
		#1 t = disp_tag;
		@(negedge sys_clk);
		disp_valid = 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic issue(input lsqu_tag_t t, input logic [15:0] ofs);
		iss_op = {t, 5'h3, ofs, 2'h3, 64'h0};
		iss_valid = 1'b1;
		@(negedge sys_clk);
		iss_valid = 1'b0;
		@(negedge sys_clk);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_xlate();
		lsqu_tag_t t;
		hit = 1'b1;
		dispatch(1'b0, t);
		issue(t, 16'h0100);
		wait_hi(rej_valid);
		`CHK(rej_tag, t)
		`CHK(tlb_req, 1'b1)
		`CHK(tlb_vpn, 28'h1234560)
		`CHK(iss_ready, 1'b0)
		repeat (12) @(negedge sys_clk);
		issue(t, 16'h0100);
		wait_hi(wb_valid);
		`CHK(wb, {t, 64'h12_3456_0100})
	endtask

	task automatic t_miss();
		lsqu_tag_t a, b, c, d;
		hit = 1'b0;
		dispatch(1'b0, a);
		dispatch(1'b0, b);
		dispatch(1'b0, c);
		dispatch(1'b0, d);
		issue(a, 16'h0208);
		wait_hi(l2_rd);
		`CHK(l2_rd_line, 33'h0_2468_ac04)
		issue(b, 16'h0230);
		issue(d, 16'h0218);
		wait_hi(rej_valid);
		`CHK(rej_tag, d)
		wait_hi(fwb0);
		`CHK(fwb[0], {a, 32'h2468_ac04, 32'h1})
		`CHK({l1_fill, l1_fill_beat, l1_fill_line}, {3'h4, 33'h0_2468_ac04})
		wait_hi(fwb1);
		`CHK(fwb[1], {b, 32'h2468_ac04, 32'h6})
		`CHK(n_rd, 1)
		issue(c, 16'h0210);
		wait_hi(l2_rd);
		@(negedge sys_clk);
		`CHK(n_rd, 2)
	endtask

	task automatic t_store();
		lsqu_tag_t s;
		rf_data = 64'h12_3456_0280;
		dispatch(1'b1, s);
		issue(s, 16'h0100);
		repeat (6) @(negedge sys_clk);
		`CHK(l2_st_valid, 1'b0)
		st_cmpl = 1'b1;
		st_cmpl_idx = s.idx;
		@(negedge sys_clk);
		st_cmpl = 1'b0;
		wait_hi(l2_st_valid);
		`CHK(l2_st.ctl, 2'h1)
		`CHK(l2_st.dw, 37'h0_2468_ac070)
		`CHK(n_wr, 0)
	endtask

	task automatic t_cast();
		l2_castout = 1'b1;
		l2_castout_line = 33'h0_2468_ac04;
		@(negedge sys_clk);
		l2_castout = 1'b0;
		wait_hi(l1_inval);
		`CHK(l1_inval_line, 33'h0_2468_ac04)
	endtask

	task automatic t_flush();
		lsqu_tag_t t;
		dispatch(1'b0, t);
		flush_lq_tail = 6'h05;
		flush_sq_tail = 6'h01;
		flush = 1'b1;
		@(negedge sys_clk);
		flush = 1'b0;
		`CHK(disp_tag, 6'h05)
	endtask

	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		hit = 1'b0;
		disp_valid = 1'b0;
		disp_st = 1'b0;
		iss_valid = 1'b0;
		iss_op = '0;
		rf_data = 64'h12_3456_0000;
		ld_retire = 1'b0;
		st_cmpl = 1'b0;
		st_cmpl_idx = '0;
		flush = 1'b0;
		flush_lq_tail = '0;
		flush_sq_tail = '0;
		l2_castout = 1'b0;
		l2_castout_line = '0;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		`CHK(disp_ready, 1'b1)
		t_xlate();
		t_miss();
		t_store();
		t_cast();
		t_flush();
		report_and_stop();
	end
endmodule

// file: src/lsqu_pkg.sv
// Overview of operation
// RULE_01: Separate 32-entry load and store order queues track ordering hazards.
// RULE_02: Every load and store gets its order queue entry at dispatch.
// RULE_03: Executing loads and stores are checked against order queue entries.
// RULE_04: Base register is read in one stage, address added in the next.
// RULE_05: Next cycle translates the address and accesses the L1 data cache.
// RULE_06: Translation miss rejects the op, keeps it queued, requests a reload.
// RULE_07: Rejected op reissues no sooner than 7 cycles after its issue.
// RULE_08: Translation cache: 128 entries, two ways, per 4 KB page.
// RULE_09: Load hit formats its bytes and writes the target register.
// RULE_10: Each load miss queues a line request; at most eight outstanding.
// RULE_11: Miss queue full rejects the missing load for later reissue.
// RULE_12: Second miss to a pending line merges into that entry. The code rejects it instead once that line's fill has begun.
// RULE_13: Third miss to a pending line is rejected.
// RULE_14: Returned lines are matched and forwarded to waiting loads.
// RULE_15: Miss queue entry is freed once its line is reloaded.
// RULE_16: Stores hold an order entry tracked by real address from issue.
// RULE_17: Store value queue holds 32 double words paired with store entries.
// RULE_18: Stores leave and go to L2 only completed and in order.
// RULE_19: Loads take store data only if fully contained and not yet written.
// RULE_20: Stores write through to L2; store misses never allocate in L1.
// RULE_21: L2 cast-out of a line invalidates the L1 copy.
// RULE_22: One store per cycle to L2, steered by hash to a controller.
// RULE_23: A store counts as completed only when its group completes.
// RULE_24: Line reloads arrive over a 32-byte data path.
// RULE_25: Flush frees flushed queue entries and cancels their pending reissues.
// RULE_26: Forwarding uses the youngest qualifying older store.
package lsqu_pkg;
	localparam int QD         = 32;
	localparam int QI         = 5;
	localparam int AW         = 40;
	localparam int PG_W       = 12;
	localparam int LN_W       = 7;
	localparam int XL_SETS    = 64;
	localparam int XL_IW      = 6;
	localparam int MRQ_D      = 8;
	localparam int FILL_W     = 256;
	localparam int FIFO_D     = 16;
	localparam int L2_CTLS    = 3;
	localparam int RETRY_CYC  = 7;
	localparam int PIPE_CYC   = 4;
	localparam int XL_RLD_CYC = 10;
	localparam logic [2:0] HOLD_CNT = 3'(RETRY_CYC - PIPE_CYC);

	typedef struct packed {
		logic          st;
		logic [QI-1:0] idx;
	} lsqu_tag_t;

	typedef struct packed {
		lsqu_tag_t   tag;
		logic [4:0]  rbase;
		logic [15:0] ofs;
		logic [1:0]  sz;
		logic [63:0] sdata;
	} lsqu_iss_t;

	typedef struct packed {
		lsqu_tag_t   tag;
		logic [63:0] data;
	} lsqu_wb_t;

	typedef struct packed {
		logic [1:0]    ctl;
		logic [AW-4:0] dw;
		logic [7:0]    mask;
		logic [63:0]   data;
	} lsqu_st_t;
endpackage

// file: src/lsqu_unit.sv
`timescale 1ns/1ps
module lsqu_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [PW:0]  wp;
	logic [PW:0]  rp;

	assign in_ready  = (wp - rp) != (PW+1)'(D);
	assign out_valid = wp != rp;
	assign out_data  = mem[rp[PW-1:0]];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp <= '0;
			rp <= '0;
		end else if (ce) begin
			if (in_valid && in_ready)
				wp <= wp + 1'b1;
			if (out_valid && out_ready)
				rp <= rp + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce && in_valid && in_ready)
			mem[wp[PW-1:0]] <= in_data;
	end
endmodule

module lsqu_unit
	import lsqu_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	// Dispatch
	input  wire logic             disp_valid,
	input  wire logic             disp_st,
	output logic                  disp_ready,
	output lsqu_tag_t             disp_tag,
	// Issue and reject
	input  wire logic             iss_valid,
	input  wire lsqu_iss_t        iss_op,
	output logic                  iss_ready,
	output logic                  rej_valid,
	output lsqu_tag_t             rej_tag,
	// Register file
	output logic [4:0]            rf_idx,
	input  wire logic [63:0]      rf_data,
	output lsqu_wb_t              wb,
	output logic                  wb_valid,
	output lsqu_wb_t              fwb [2],
	output logic [1:0]            fwb_valid,
	// Completion and flush
	input  wire logic             ld_retire,
	input  wire logic             st_cmpl,
	input  wire logic [QI-1:0]    st_cmpl_idx,
	input  wire logic             flush,
	input  wire logic [QI:0]      flush_lq_tail,
	input  wire logic [QI:0]      flush_sq_tail,
	output logic                  ord_hazard,
	output lsqu_tag_t             ord_tag,
	// Translation reload
	output logic                  tlb_req,
	output logic [AW-PG_W-1:0]    tlb_vpn,
	input  wire logic             tlb_rsp,
	input  wire logic [AW-PG_W-1:0] tlb_rpn,
	// L1 data cache array
	output logic [AW-1:0]         l1_rd_ea,
	input  wire logic [1:0]       l1_tv,
	input  wire logic [AW-LN_W-1:0] l1_tag [2],
	input  wire logic [63:0]      l1_dw [2],
	output logic                  l1_wr,
	output lsqu_st_t              l1_wr_op,
	output logic                  l1_fill,
	output logic [AW-LN_W-1:0]    l1_fill_line,
	output logic [1:0]            l1_fill_beat,
	output logic [FILL_W-1:0]     l1_fill_data,
	output logic                  l1_inval,
	output logic [AW-LN_W-1:0]    l1_inval_line,
	// L2 side
	output logic                  l2_rd,
	output logic [AW-LN_W-1:0]    l2_rd_line,
	input  wire logic             l2_fill,
	input  wire logic [AW-LN_W-1:0] l2_fill_line,
	input  wire logic [1:0]       l2_fill_beat,
	input  wire logic [FILL_W-1:0] l2_fill_data,
	input  wire logic             l2_castout,
	input  wire logic [AW-LN_W-1:0] l2_castout_line,
	output logic                  l2_st_valid,
	input  wire logic             l2_st_ready,
	output lsqu_st_t              l2_st
);
	function automatic logic [7:0] szm(input logic [1:0] sz);
		return (sz == 2'd0) ? 8'h01 : (sz == 2'd1) ? 8'h03 : (sz == 2'd2) ? 8'h0f : 8'hff;
	endfunction

	function automatic logic [63:0] fmt(input logic [63:0] dw, input logic [2:0] off,
		input logic [1:0] sz);
		logic [63:0] t;
		logic [7:0]  m;
		m = szm(sz);
		t = dw >> {off, 3'b000};
		for (int b = 0; b < 8; b++)
			if (!m[b])
				t[b*8 +: 8] = 8'h00;
		return t;
	endfunction

	// =========================================================
	// Order queues and store value queue
	logic [QI:0]   lq_hd, lq_tl, sq_hd, sq_tl;
	logic [QD-1:0] lq_v, lq_done, sq_v, sq_av, sq_cmp;
	logic [QI:0]   lq_sn [QD];
	logic [AW-4:0] lq_dw [QD], sq_dw [QD];
	logic [7:0]    lq_mk [QD], sq_mk [QD];
	logic [63:0]   sq_data [QD];
	logic [2:0]    hold [2*QD];
	logic [2*QD-1:0] kill;
	logic          disp_fire, iss_fire, sq_pop, st_push, st_in_rdy;
	lsqu_st_t      st_head;

	assign disp_ready = disp_st ? (sq_tl - sq_hd) != (QI+1)'(QD) : (lq_tl - lq_hd) != (QI+1)'(QD);
	assign disp_fire  = disp_valid && disp_ready && !flush;
	assign disp_tag   = '{st: disp_st, idx: disp_st ? sq_tl[QI-1:0] : lq_tl[QI-1:0]};
	assign iss_ready  = hold[iss_op.tag] == 3'd0;
	assign iss_fire   = iss_valid && iss_ready && !flush;

	// Tags beyond the flush tails
	always_comb begin
		for (int i = 0; i < QD; i++) begin
			kill[i]      = flush && 5'(i - lq_hd[QI-1:0]) >= 5'(flush_lq_tail - lq_hd)
				&& flush_lq_tail != lq_tl ? 1'b1 : 1'b0;
			kill[QD + i] = flush && 5'(i - sq_hd[QI-1:0]) >= 5'(flush_sq_tail - sq_hd)
				&& flush_sq_tail != sq_tl ? 1'b1 : 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lq_hd <= '0;
			lq_tl <= '0;
			sq_hd <= '0;
			sq_tl <= '0;
		end else if (ce) begin
			if (flush) begin
				lq_tl <= flush_lq_tail; // see RULE_25
				sq_tl <= flush_sq_tail;
			end else if (disp_fire && disp_st)
				sq_tl <= sq_tl + 1'b1; // see RULE_02
			else if (disp_fire)
				lq_tl <= lq_tl + 1'b1;
			if (ld_retire && lq_v[lq_hd[QI-1:0]])
				lq_hd <= lq_hd + 1'b1;
			if (sq_pop)
				sq_hd <= sq_hd + 1'b1; // see RULE_18
		end
	end

	// =========================================================
	// Register fetch, address generation and cache access stages
	logic          r_v, a_v, d_v;
	lsqu_iss_t     r_op, a_op, d_op;
	logic [AW-1:0] d_ea, a_base;

	assign rf_idx   = r_op.rbase;
	assign l1_rd_ea = d_ea;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_v  <= 1'b0;
			a_v  <= 1'b0;
			d_v  <= 1'b0;
			r_op <= '0;
			a_op <= '0;
			d_op <= '0;
			d_ea <= '0;
		end else if (ce) begin
			r_v  <= iss_fire;
			r_op <= iss_op;
			a_v  <= r_v && !kill[r_op.tag];
			a_op <= r_op;
			a_base <= rf_data[AW-1:0];
			a_op.sdata <= r_op.tag.st ? rf_data : r_op.sdata; // see RULE_04
			d_v  <= a_v && !kill[a_op.tag];
			d_op <= a_op;
			d_ea <= a_base + AW'(signed'(a_op.ofs)); // see RULE_04
		end
	end

	// =========================================================
	// Translation cache lookup and reload
	logic             xl_v [2][XL_SETS];
	logic [AW-19:0]   xl_tg [2][XL_SETS];
	logic [AW-13:0]   xl_rp [2][XL_SETS];
	logic [XL_SETS-1:0] xl_rr;
	logic             xl_hit, rld_busy;
	logic [AW-1:0]    ra;
	logic [AW-13:0]   rld_vpn;
	logic [XL_IW-1:0] xs, rs;

	assign xs = d_ea[PG_W +: XL_IW];
	assign rs = rld_vpn[XL_IW-1:0];
	always_comb begin
		xl_hit = 1'b0;
		ra     = '0;
		for (int w = 0; w < 2; w++)
			if (xl_v[w][xs] && xl_tg[w][xs] == d_ea[AW-1:PG_W+XL_IW]) begin
				xl_hit = 1'b1; // see RULE_05
				ra     = {xl_rp[w][xs], d_ea[PG_W-1:0]};
			end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			xl_v     <= '{default: '{default: 1'b0}};
			xl_rr    <= '0;
			rld_busy <= 1'b0;
			rld_vpn  <= '0;
			tlb_req  <= 1'b0;
			tlb_vpn  <= '0;
		end else if (ce) begin
			tlb_req <= 1'b0;
			if (d_v && !xl_hit && !rld_busy) begin
				rld_busy <= 1'b1; // see RULE_06
				rld_vpn  <= d_ea[AW-1:PG_W];
				tlb_req  <= 1'b1;
				tlb_vpn  <= d_ea[AW-1:PG_W];
			end else if (tlb_rsp && rld_busy) begin
				rld_busy              <= 1'b0; // see RULE_08
				xl_v[xl_rr[rs]][rs]   <= 1'b1;
				xl_tg[xl_rr[rs]][rs]  <= rld_vpn[AW-13:XL_IW];
				xl_rp[xl_rr[rs]][rs]  <= tlb_rpn;
				xl_rr[rs]             <= ~xl_rr[rs];
			end
		end
	end

	// =========================================================
	// Cache hit, store forwarding and ordering check
	logic [7:0]    lmk;
	logic          l1_hit, fw_ov, fw_ok, hz;
	logic [63:0]   l1_data;
	logic [QI-1:0] fw_i, hz_i;
	logic [QI:0]   lsn_d;
	logic [QI-1:0] best;

	assign lmk   = 8'(szm(d_op.sz) << d_ea[2:0]);
	assign lsn_d = lq_sn[d_op.tag.idx] - sq_hd;
	always_comb begin
		l1_hit  = 1'b0;
		l1_data = '0;
		fw_ov   = 1'b0;
		fw_i    = '0;
		best    = '0;
		hz      = 1'b0;
		hz_i    = '0;
		for (int w = 0; w < 2; w++)
			if (l1_tv[w] && l1_tag[w] == ra[AW-1:LN_W]) begin
				l1_hit  = 1'b1;
				l1_data = l1_dw[w];
			end
		for (int i = 0; i < QD; i++) begin
			if (sq_v[i] && sq_av[i] && {1'b0, 5'(i - sq_hd[QI-1:0])} < lsn_d
				&& sq_dw[i] == ra[AW-1:3] && (sq_mk[i] & lmk) != 8'h00
				&& (!fw_ov || 5'(i - sq_hd[QI-1:0]) >= best)) begin
				fw_ov = 1'b1; // see RULE_26
				fw_i  = QI'(i);
				best  = 5'(i - sq_hd[QI-1:0]);
			end
			if (lq_v[i] && lq_done[i] && lq_dw[i] == ra[AW-1:3] && (lq_mk[i] & lmk) != 8'h00
				&& {1'b0, 5'(d_op.tag.idx - sq_hd[QI-1:0])} < lq_sn[i] - sq_hd) begin
				hz   = 1'b1; // see RULE_03
				hz_i = QI'(i);
			end
		end
	end
	assign fw_ok = fw_ov && (lmk & ~sq_mk[fw_i]) == 8'h00; // see RULE_19

	// =========================================================
	// Miss request queue
	logic [MRQ_D-1:0] mq_v, mq_two, mq_fs;
	logic [AW-8:0]    mq_ln [MRQ_D];
	lsqu_tag_t        mq_tg [MRQ_D][2];
	logic [6:0]       mq_lo [MRQ_D][2];
	logic [1:0]       mq_sz [MRQ_D][2];
	logic             mq_m, mq_free, ld_miss, ld_rej, d_ld, d_rej;
	logic [2:0]       mq_mi, mq_fi;

	assign d_ld    = d_v && !d_op.tag.st && !kill[d_op.tag] && xl_hit;
	assign ld_miss = d_ld && !fw_ov && !l1_hit;
	always_comb begin
		mq_m    = 1'b0;
		mq_mi   = '0;
		mq_free = 1'b0;
		mq_fi   = '0;
		for (int e = MRQ_D - 1; e >= 0; e--) begin
			if (mq_v[e] && mq_ln[e] == ra[AW-1:LN_W]
				&& !(l2_fill && l2_fill_beat == 2'd3 && l2_fill_line == mq_ln[e])) begin
				mq_m  = 1'b1;
				mq_mi = 3'(e);
			end
			if (!mq_v[e]) begin
				mq_free = 1'b1;
				mq_fi   = 3'(e);
			end
		end
	end
	// Merge only into an entry holding one load whose fill has not begun
	assign ld_rej = ld_miss && (mq_m ? (mq_two[mq_mi] || mq_fs[mq_mi] // see RULE_13
		|| (l2_fill && l2_fill_line == mq_ln[mq_mi])) : !mq_free);
	assign d_rej  = d_v && !kill[d_op.tag] && (!xl_hit || ld_rej || (d_ld && fw_ov && !fw_ok));

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mq_v       <= '0;
			mq_two     <= '0;
			mq_fs      <= '0;
			l2_rd      <= 1'b0;
			l2_rd_line <= '0;
			fwb_valid  <= '0;
			fwb        <= '{default: '0};
		end else if (ce) begin
			l2_rd     <= 1'b0;
			fwb_valid <= '0;
			for (int e = 0; e < MRQ_D; e++)
				if (l2_fill && mq_v[e] && mq_ln[e] == l2_fill_line) begin
					mq_fs[e] <= 1'b1;
					for (int k = 0; k < 2; k++)
						if ((k == 0 || mq_two[e]) && mq_lo[e][k][6:5] == l2_fill_beat
							&& !kill[mq_tg[e][k]]) begin
							fwb_valid[k] <= 1'b1; // see RULE_14
							fwb[k].tag   <= mq_tg[e][k];
							fwb[k].data  <= fmt(l2_fill_data[mq_lo[e][k][4:3]*64 +: 64],
								mq_lo[e][k][2:0], mq_sz[e][k]);
						end
					if (l2_fill_beat == 2'd3) begin
						mq_v[e]  <= 1'b0; // see RULE_15
						mq_fs[e] <= 1'b0;
					end
				end
			if (ld_miss && !ld_rej && mq_m) begin
				mq_two[mq_mi]   <= 1'b1; // see RULE_12
				mq_tg[mq_mi][1] <= d_op.tag;
				mq_lo[mq_mi][1] <= ra[6:0];
				mq_sz[mq_mi][1] <= d_op.sz;
			end else if (ld_miss && !ld_rej) begin
				mq_v[mq_fi]     <= 1'b1; // see RULE_10
				mq_two[mq_fi]   <= 1'b0;
				mq_ln[mq_fi]    <= ra[AW-1:LN_W];
				mq_tg[mq_fi][0] <= d_op.tag;
				mq_lo[mq_fi][0] <= ra[6:0];
				mq_sz[mq_fi][0] <= d_op.sz;
				l2_rd           <= 1'b1;
				l2_rd_line      <= ra[AW-1:LN_W];
			end
		end
	end

	// =========================================================
	// Queue entry state
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lq_v    <= '0;
			lq_done <= '0;
			sq_v    <= '0;
			sq_av   <= '0;
			sq_cmp  <= '0;
		end else if (ce) begin
			if (ld_retire)
				lq_v[lq_hd[QI-1:0]] <= 1'b0;
			if (sq_pop)
				sq_v[sq_hd[QI-1:0]] <= 1'b0;
			if (st_cmpl)
				sq_cmp[st_cmpl_idx] <= 1'b1; // see RULE_23
			if (d_ld && !d_rej) begin
				lq_done[d_op.tag.idx] <= 1'b1;
				lq_dw[d_op.tag.idx]   <= ra[AW-1:3];
				lq_mk[d_op.tag.idx]   <= lmk;
			end
			if (d_v && d_op.tag.st && !d_rej) begin
				sq_av[d_op.tag.idx]   <= 1'b1; // see RULE_16
				sq_dw[d_op.tag.idx]   <= ra[AW-1:3];
				sq_mk[d_op.tag.idx]   <= lmk;
				sq_data[d_op.tag.idx] <= d_op.sdata << {d_ea[2:0], 3'b000}; // see RULE_17
			end
			if (disp_fire && disp_st) begin
				sq_v[sq_tl[QI-1:0]]   <= 1'b1; // see RULE_01
				sq_av[sq_tl[QI-1:0]]  <= 1'b0;
				sq_cmp[sq_tl[QI-1:0]] <= 1'b0;
			end else if (disp_fire) begin
				lq_v[lq_tl[QI-1:0]]    <= 1'b1; // see RULE_01
				lq_done[lq_tl[QI-1:0]] <= 1'b0;
				lq_sn[lq_tl[QI-1:0]]   <= sq_tl;
			end
			for (int i = 0; i < QD; i++) begin
				if (kill[i])
					lq_v[i] <= 1'b0; // see RULE_25
				if (kill[QD + i])
					sq_v[i] <= 1'b0;
			end
		end
	end

	// =========================================================
	// Reissue holds, writeback, L1 updates
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold <= '{default: 3'd0};
		end else if (ce) begin
			for (int t = 0; t < 2*QD; t++)
				if (kill[t])
					hold[t] <= 3'd0; // see RULE_25
				else if (d_rej && d_op.tag == 6'(t))
					hold[t] <= HOLD_CNT; // see RULE_07
				else if (hold[t] != 3'd0)
					hold[t] <= hold[t] - 3'd1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rej_valid     <= 1'b0;
			rej_tag       <= '0;
			wb_valid      <= 1'b0;
			wb            <= '0;
			ord_hazard    <= 1'b0;
			ord_tag       <= '0;
			l1_wr         <= 1'b0;
			l1_wr_op      <= '0;
			l1_fill       <= 1'b0;
			l1_fill_line  <= '0;
			l1_fill_beat  <= '0;
			l1_fill_data  <= '0;
			l1_inval      <= 1'b0;
			l1_inval_line <= '0;
		end else if (ce) begin
			rej_valid  <= d_rej; // see RULE_11
			rej_tag    <= d_op.tag;
			wb_valid   <= d_ld && !d_rej && (fw_ok || (!fw_ov && l1_hit)); // see RULE_09
			wb.tag     <= d_op.tag;
			wb.data    <= fmt(fw_ok ? sq_data[fw_i] : l1_data, d_ea[2:0], d_op.sz);
			ord_hazard <= d_v && d_op.tag.st && !d_rej && hz;
			ord_tag    <= '{st: 1'b0, idx: hz_i};
			// Write-through stores only touch L1 on a hit
			l1_wr      <= d_v && d_op.tag.st && !d_rej && l1_hit; // see RULE_20
			l1_wr_op   <= '{ctl: 2'd0, dw: ra[AW-1:3], mask: lmk,
				data: d_op.sdata << {d_ea[2:0], 3'b000}};
			l1_fill      <= l2_fill; // see RULE_24
			l1_fill_line <= l2_fill_line;
			l1_fill_beat <= l2_fill_beat;
			l1_fill_data <= l2_fill_data;
			l1_inval      <= l2_castout; // see RULE_21
			l1_inval_line <= l2_castout_line;
		end
	end

	// =========================================================
	// Store drain toward the L2 controllers
	assign sq_pop  = sq_v[sq_hd[QI-1:0]] && sq_av[sq_hd[QI-1:0]] && sq_cmp[sq_hd[QI-1:0]]
		&& st_in_rdy; // see RULE_18
	assign st_push = sq_pop;
	assign st_head = '{ctl: 2'(sq_dw[sq_hd[QI-1:0]][LN_W-3 +: 4] % 4'(L2_CTLS)),
		dw: sq_dw[sq_hd[QI-1:0]], mask: sq_mk[sq_hd[QI-1:0]],
		data: sq_data[sq_hd[QI-1:0]]}; // see RULE_22

	lsqu_fifo #(.W($bits(lsqu_st_t)), .D(FIFO_D)) u_st_fifo (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.in_valid  (st_push),
		.in_ready  (st_in_rdy),
		.in_data   (st_head),
		.out_valid (l2_st_valid),
		.out_ready (l2_st_ready),
		.out_data  (l2_st)
	);

	// =========================================================
	// Assertions
	sequence s_rej_seen;
		rej_valid;
	endsequence
	sequence s_no_reissue(lsqu_tag_t t);
		!(iss_fire && iss_op.tag == t);
	endsequence
	property p_retry;
		@(posedge sys_clk) disable iff (sys_rst)
		ce ##0 s_rej_seen |-> s_no_reissue(rej_tag) ##1 s_no_reissue($past(rej_tag))
			##1 s_no_reissue($past(rej_tag, 2));
	endproperty
	a_retry: assert property (p_retry) else $error("reissue inside retry window"); // see RULE_07
	property p_xl_miss;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && d_v && !kill[d_op.tag] && !xl_hit) |=> rej_valid && (rld_busy || $past(tlb_rsp));
	endproperty
	a_xl_miss: assert property (p_xl_miss) else $error("translation miss not rejected"); // see RULE_06
	property p_full;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && ld_miss && !mq_m && mq_v == 8'hff) |=> rej_valid && !l2_rd;
	endproperty
	a_full: assert property (p_full) else $error("load accepted with full miss queue"); // see RULE_11
	property p_merge;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && ld_miss && mq_m && !ld_rej) |=> !l2_rd && !rej_valid && mq_two[$past(mq_mi)];
	endproperty
	a_merge: assert property (p_merge) else $error("merge issued a second request"); // see RULE_12
	property p_release;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && l2_fill && l2_fill_beat == 2'd3 && mq_v[0] && mq_ln[0] == l2_fill_line)
		|=> !mq_v[0];
	endproperty
	a_release: assert property (p_release) else $error("entry kept after reload"); // see RULE_15
	property p_hit;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && d_ld && !d_rej && l1_hit && !fw_ov) |=> wb_valid && wb.tag == $past(d_op.tag);
	endproperty
	a_hit: assert property (p_hit) else $error("hit load not written back"); // see RULE_09
	property p_castout;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && l2_castout) |=> l1_inval && l1_inval_line == $past(l2_castout_line);
	endproperty
	a_castout: assert property (p_castout) else $error("cast-out not invalidated"); // see RULE_21
	property p_order;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && sq_pop) |=> sq_hd == $past(sq_hd) + 1'b1 && !sq_v[$past(sq_hd[QI-1:0])];
	endproperty
	a_order: assert property (p_order) else $error("store left out of order"); // see RULE_18
	property p_flush;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && flush) |=> lq_tl == $past(flush_lq_tail) && sq_tl == $past(flush_sq_tail);
	endproperty
	a_flush: assert property (p_flush) else $error("flush tails not restored"); // see RULE_25
endmodule
